// file: core/ltxe_defs.svh
`ifndef LTXE_DEFS_SVH
`define LTXE_DEFS_SVH

// Register indexes; the byte address on the bus is four times the index
`define LTXE_IDX_GLOBAL   8'h40
`define LTXE_IDX_CFG      8'h02
`define LTXE_IDX_PULSE    8'h03
`define LTXE_IDX_SCALE    8'h04
`define LTXE_IDX_RAMCTL   8'h05
`define LTXE_IDX_SAMPLE   8'h06
`define LTXE_IDX_MASK     8'h12
`define LTXE_IDX_STATUS   8'h17

// Field positions in the interface configuration register
`define LTXE_CFG_ENC      0
`define LTXE_CFG_RAIL     1
`define LTXE_CFG_INV      2
`define LTXE_CFG_EDGE     3

// Field positions in the waveform RAM control register
`define LTXE_CTL_RW       6
`define LTXE_CTL_DONE     7

// Status and mask bit positions
`define LTXE_ST_LOSS      0
`define LTXE_ST_OVF       1

// Timing and amplitude figures
`define LTXE_TCLK_LOSS    7'h46
`define LTXE_PHASE_DIV    3'h7
`define LTXE_PHASE_LAST   4'hf
`define LTXE_PHASE_HALF   4'h8
`define LTXE_ARB_CODE     2'h3
`define LTXE_SCAL_SHIFT   5
`define LTXE_AMP_MAX      6'h3f
`define LTXE_SCAL_RESET   6'h20

`endif

// file: core/ltxe_pkg.sv
package ltxe_pkg;

    // Line symbols held in the encoder window
    typedef enum logic [1:0] {
        sym_zero,
        sym_one,
        sym_viol
    } ltxe_sym_e;

    // Software visible configuration and status
    typedef struct packed {
        logic       line_std;   // 0 E1, 1 T1/J1
        logic       edge_sel;   // 0 rising, 1 falling clock edge
        logic       invert;     // Data inputs active low
        logic       rail;       // 0 single rail, 1 dual rail
        logic       enc;        // 1 zero substitution, 0 plain AMI
        logic [3:0] pulse;      // Pulse select field
        logic [5:0] scal;       // Scaling field
        logic [1:0] ui;         // Interval select field
        logic [3:0] samp;       // Sample address field
        logic       rw;         // 0 write RAM, 1 read RAM
        logic       done;       // Access trigger, self clearing
        logic [6:0] sample;     // Sample data field
        logic [1:0] mask;       // Interrupt enables
        logic [1:0] status;     // Sticky events
    } ltxe_cfg_s;

    // Whole module state
    typedef struct packed {
        ltxe_cfg_s            cfg;
        logic                 waitreq;   // Avalon waitrequest
        logic [7:0]           rdata;     // Avalon read data
        logic                 ram_go;    // RAM access pending
        logic [2:0]           tclk_s;    // Sync stages plus edge history
        logic [1:0]           dp_s;      // Positive data sync
        logic [1:0]           dn_s;      // Negative data sync
        logic [6:0]           miss_cnt;  // Cycles since last clock edge
        ltxe_sym_e [7:0]      ent;       // Encoder window, [0] newest
        logic                 hdb_odd;   // Odd mark count since last V
        logic                 last_pol;  // Polarity of last pulse
        logic                 line_pos;
        logic                 line_neg;
        logic [3:0][1:0]      hist;      // {pos,neg} of recent pulses
        logic [3:0]           phase;     // Sub-phase in current UI
        logic [2:0]           div;       // Sub-phase divider
        logic [6:0]           dac;       // Sign-magnitude amplitude
        logic                 irq;
    } ltxe_state_s;

endpackage

// file: core/ltxe_top.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "ltxe_defs.svh"
module ltxe_top (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Avalon-MM register slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // System transmit interface
    input  wire logic        tx_clock_in,
    input  wire logic        tx_data_pos_in,
    input  wire logic        tx_data_neg_in,
    // Line driver side
    output logic             line_tx_pair_pos,
    output logic             line_tx_pair_neg,
    output logic      [6:0]  line_tx_pair_amp,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // State, RAM and template ROM

    ltxe_pkg::ltxe_state_s st_r;     // All registered state
    ltxe_pkg::ltxe_state_s st_nxt;   // Next value of the state
    logic [6:0] wave_ram [64];       // Waveform samples, {ui, samp}

    // Peak amplitude of each stored template, indexed by pulse code
    // Codes 0-1 E1, 2-6 T1 grades, 7 J1, 8-11 long haul grades
    localparam logic [5:0] TEMPL_PEAK [12] = '{
        6'h3c, 6'h3a, 6'h30, 6'h34, 6'h38, 6'h3c, 6'h3f, 6'h36,
        6'h3f, 6'h1a, 6'h0b, 6'h05
    };

    ////////////////////////////////////////////////////////////////////////
    // Combinational helpers

    logic       tclk_rise;      // Rising edge of synced clock
    logic       tclk_fall;      // Falling edge of synced clock
    logic       bit_tick;       // Active edge, one bit per tick
    logic       d_pos;          // Positive data after inversion
    logic       d_neg;          // Negative data after inversion
    logic       arb_mode;       // Arbitrary waveform selected
    logic [5:0] ram_addr;       // Software RAM address
    logic [7:0] reg_idx;        // Register index from byte address
    logic [7:0] reg_rd;         // Read mux output
    logic       req;            // Any bus request

    assign tclk_rise = st_r.tclk_s[1] & ~st_r.tclk_s[2];
    assign tclk_fall = ~st_r.tclk_s[1] & st_r.tclk_s[2];
    // Active edge chosen by edge_sel
    assign bit_tick  = st_r.cfg.edge_sel ? tclk_fall : tclk_rise;
    // Inputs read active high or active low
    assign d_pos     = st_r.dp_s[1] ^ st_r.cfg.invert;
    assign d_neg     = st_r.dn_s[1] ^ st_r.cfg.invert;
    // Top two bits of pulse code both set
    assign arb_mode  = (st_r.cfg.pulse[3:2] == `LTXE_ARB_CODE);
    assign ram_addr  = {st_r.cfg.ui, st_r.cfg.samp};
    assign reg_idx   = avs_address[9:2];
    assign req       = avs_read | avs_write;

    ////////////////////////////////////////////////////////////////////////
    // Arbitrary waveform: overlap of four intervals, then scaling

    logic signed [7:0]  term [4];   // Contribution of each interval
    logic signed [9:0]  wave_sum;   // Sum of overlapping pulses
    logic signed [16:0] wave_prod;  // Sum times scaling field
    logic signed [16:0] wave_scl;   // Scaled amplitude
    logic        [16:0] wave_mag;   // Magnitude of scaled amplitude
    logic               wave_ovf;   // Beyond full scale
    logic        [6:0]  arb_dac;    // Sign-magnitude result
    logic        [6:0]  pre_dac;    // Preset template result
    logic        [5:0]  pre_peak;   // Peak of selected template

    // One term per interval; hist[g] is the pulse sent g UIs ago
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_ui
        logic [6:0] smp;   // Sign-magnitude sample
        assign smp = wave_ram[{2'(g), st_r.phase}];
        assign term[g] = (st_r.hist[g] == 2'h0) ? 8'sh00 :
                         ((smp[6] ^ st_r.hist[g][0]) ?
                          -$signed({2'h0, smp[5:0]}) :
                          $signed({2'h0, smp[5:0]}));
    end

    // Scaling only acts in arbitrary mode
    always_comb
    begin
        wave_sum  = 10'(term[0]) + 10'(term[1]) + 10'(term[2])
                  + 10'(term[3]);
        wave_prod = 17'(wave_sum) * $signed({11'h0, st_r.cfg.scal});
        wave_scl  = wave_prod >>> `LTXE_SCAL_SHIFT;
        wave_mag  = wave_scl[16] ? 17'(-wave_scl) : 17'(wave_scl);
        // Overlapping pulses may exceed full scale
        wave_ovf  = wave_mag > 17'(`LTXE_AMP_MAX);
        arb_dac   = {wave_scl[16],
                     wave_ovf ? `LTXE_AMP_MAX : wave_mag[5:0]};
    end

    // Presets use the ROM shape, never scaled
    always_comb
    begin
        pre_peak = TEMPL_PEAK[arb_mode ? 4'h0 : st_r.cfg.pulse];
        if (st_r.hist[0] != 2'h0 && st_r.phase < `LTXE_PHASE_HALF)
            pre_dac = {st_r.hist[0][0], pre_peak};
        else
            pre_dac = 7'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux

    always_comb
    begin
        unique case (reg_idx)
            `LTXE_IDX_GLOBAL: reg_rd = {7'h0, st_r.cfg.line_std};
            `LTXE_IDX_CFG:    reg_rd = {4'h0, st_r.cfg.edge_sel,
                                        st_r.cfg.invert, st_r.cfg.rail,
                                        st_r.cfg.enc};
            `LTXE_IDX_PULSE:  reg_rd = {4'h0, st_r.cfg.pulse};
            `LTXE_IDX_SCALE:  reg_rd = {2'h0, st_r.cfg.scal};
            `LTXE_IDX_RAMCTL: reg_rd = {st_r.cfg.done, st_r.cfg.rw,
                                        st_r.cfg.ui, st_r.cfg.samp};
            `LTXE_IDX_SAMPLE: reg_rd = {1'h0, st_r.cfg.sample};
            `LTXE_IDX_MASK:   reg_rd = {6'h0, st_r.cfg.mask};
            `LTXE_IDX_STATUS: reg_rd = {6'h0, st_r.cfg.status};
            // Unmapped addresses read as zero
            default:          reg_rd = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [1:0] set_ev;     // Events raised this cycle
        logic [1:0] clr_ev;     // Status bits cleared by a read
        logic       pos_o;      // Pulse polarity leaving the encoder
        logic       neg_o;
        ltxe_pkg::ltxe_sym_e [7:0] ent_n;
        set_ev = 2'h0;
        clr_ev = 2'h0;
        pos_o  = 1'b0;
        neg_o  = 1'b0;
        ent_n  = st_r.ent;
        st_nxt = st_r;

        // Two-flop synchronisers; stage 2 of the clock feeds edge history
        st_nxt.tclk_s = {st_r.tclk_s[1:0], tx_clock_in};
        st_nxt.dp_s   = {st_r.dp_s[0], tx_data_pos_in};
        st_nxt.dn_s   = {st_r.dn_s[0], tx_data_neg_in};

        // Missing clock watchdog, saturating just past the limit
        if (tclk_rise | tclk_fall)
            st_nxt.miss_cnt = 7'h00;
        else if (st_r.miss_cnt <= `LTXE_TCLK_LOSS)
            st_nxt.miss_cnt = st_r.miss_cnt + 7'h01;
        if (!(tclk_rise | tclk_fall) && st_r.miss_cnt == `LTXE_TCLK_LOSS)
            set_ev[`LTXE_ST_LOSS] = 1'b1;

        // Sub-phase timebase restarts with each bit
        if (bit_tick)
        begin
            st_nxt.div   = 3'h0;
            st_nxt.phase = 4'h0;
        end
        else if (st_r.div == `LTXE_PHASE_DIV)
        begin
            st_nxt.div = 3'h0;
            if (st_r.phase != `LTXE_PHASE_LAST)
                st_nxt.phase = st_r.phase + 4'h1;
        end
        else
            st_nxt.div = st_r.div + 3'h1;

        // One line symbol per active clock edge
        if (bit_tick)
        begin
            if (st_r.cfg.rail)
            begin
                // Encoder bypassed in dual rail
                pos_o = ~d_pos & d_neg;
                neg_o = d_pos & ~d_neg;
                ent_n = {st_r.ent[6:0], ltxe_pkg::sym_zero};
            end
            else
            begin
                // Oldest symbol leaves the window with its polarity
                unique case (st_r.ent[7])
                    ltxe_pkg::sym_one:
                    begin
                        pos_o = ~st_r.last_pol;
                        neg_o = st_r.last_pol;
                    end
                    ltxe_pkg::sym_viol:
                    begin
                        pos_o = st_r.last_pol;
                        neg_o = ~st_r.last_pol;
                    end
                    default:
                    begin
                        pos_o = 1'b0;
                        neg_o = 1'b0;
                    end
                endcase
                if (pos_o | neg_o)
                    st_nxt.last_pol = pos_o;
                ent_n = {st_r.ent[6:0],
                         d_pos ? ltxe_pkg::sym_one : ltxe_pkg::sym_zero};
                if (d_pos)
                    st_nxt.hdb_odd = ~st_r.hdb_odd;
                // Eight zeros become 000VB0VB on T1/J1
                if (st_r.cfg.enc && st_r.cfg.line_std && ent_n == '0)
                    ent_n = {ltxe_pkg::sym_zero, ltxe_pkg::sym_zero,
                             ltxe_pkg::sym_zero, ltxe_pkg::sym_viol,
                             ltxe_pkg::sym_one, ltxe_pkg::sym_zero,
                             ltxe_pkg::sym_viol, ltxe_pkg::sym_one};
                // Four zeros become 000V or B00V on E1
                if (st_r.cfg.enc && !st_r.cfg.line_std
                    && ent_n[3:0] == '0)
                begin
                    ent_n[0] = ltxe_pkg::sym_viol;
                    ent_n[3] = st_r.hdb_odd ? ltxe_pkg::sym_zero
                                            : ltxe_pkg::sym_one;
                    st_nxt.hdb_odd = 1'b0;
                end
            end
            st_nxt.ent      = ent_n;
            st_nxt.line_pos = pos_o;
            st_nxt.line_neg = neg_o;
            st_nxt.hist     = {st_r.hist[2:0], pos_o, neg_o};
        end

        // Amplitude toward the line driver
        if (arb_mode)
        begin
            st_nxt.dac = arb_dac;
            set_ev[`LTXE_ST_OVF] = wave_ovf;
        end
        else
            st_nxt.dac = pre_dac;

        // Triggered RAM access; a read returns the sample
        if (st_r.ram_go)
        begin
            st_nxt.ram_go   = 1'b0;
            st_nxt.cfg.done = 1'b0;
            if (st_r.cfg.rw)
                st_nxt.cfg.sample = wave_ram[ram_addr];
        end

        // Avalon slave: one wait cycle, then accept
        if (req && st_r.waitreq)
        begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata   = avs_read ? reg_rd : 8'h00;
        end
        else if (req)
        begin
            st_nxt.waitreq = 1'b1;
            // Reading status clears only the bits it reported
            if (avs_read && reg_idx == `LTXE_IDX_STATUS)
                clr_ev = st_r.rdata[1:0];
            if (avs_write && avs_byteenable[0])
            begin
                unique case (reg_idx)
                    `LTXE_IDX_GLOBAL:
                        st_nxt.cfg.line_std = avs_writedata[0];
                    `LTXE_IDX_CFG:
                    begin
                        st_nxt.cfg.enc  = avs_writedata[`LTXE_CFG_ENC];
                        st_nxt.cfg.rail = avs_writedata[`LTXE_CFG_RAIL];
                        st_nxt.cfg.invert = avs_writedata[`LTXE_CFG_INV];
                        st_nxt.cfg.edge_sel =
                            avs_writedata[`LTXE_CFG_EDGE];
                    end
                    `LTXE_IDX_PULSE: st_nxt.cfg.pulse = avs_writedata[3:0];
                    `LTXE_IDX_SCALE: st_nxt.cfg.scal  = avs_writedata[5:0];
                    `LTXE_IDX_RAMCTL:
                    begin
                        st_nxt.cfg.samp   = avs_writedata[3:0];
                        st_nxt.cfg.ui     = avs_writedata[5:4];
                        st_nxt.cfg.rw     = avs_writedata[`LTXE_CTL_RW];
                        st_nxt.cfg.done   = avs_writedata[`LTXE_CTL_DONE];
                        st_nxt.ram_go     = avs_writedata[`LTXE_CTL_DONE];
                    end
                    `LTXE_IDX_SAMPLE:
                        st_nxt.cfg.sample = avs_writedata[6:0];
                    `LTXE_IDX_MASK: st_nxt.cfg.mask = avs_writedata[1:0];
                    // Status is read-only, unmapped writes vanish
                    default: st_nxt.cfg.mask = st_r.cfg.mask;
                endcase
            end
        end

        // Sticky status: a new event wins over a clear
        st_nxt.cfg.status = (st_r.cfg.status & ~clr_ev) | set_ev;
        st_nxt.irq        = |(st_nxt.cfg.status & st_r.cfg.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r             <= '0;
            st_r.waitreq     <= 1'b1;
            st_r.cfg.scal    <= `LTXE_SCAL_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // RAM write port, one cycle after the trigger
    always_ff @(posedge core_clk)
    begin
        if (st_r.ram_go && !st_r.cfg.rw)
            wave_ram[ram_addr] <= st_r.cfg.sample;
    end

    // Outputs straight from the state register
    assign avs_readdata     = {24'h0, st_r.rdata};
    assign avs_waitrequest  = st_r.waitreq;
    assign line_tx_pair_pos = st_r.line_pos;
    assign line_tx_pair_neg = st_r.line_neg;
    assign line_tx_pair_amp = st_r.dac;
    assign irq              = st_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_trig;
        st_r.ram_go && !rst;
    endsequence
    sequence s_done_clear;
        !st_r.ram_go && !st_r.cfg.done;
    endsequence

    property p_loss;
        @(posedge core_clk) disable iff (rst)
        (!(tclk_rise | tclk_fall) && st_r.miss_cnt == `LTXE_TCLK_LOSS)
        |=> st_r.cfg.status[`LTXE_ST_LOSS];
    endproperty
    a_loss: assert property (p_loss) else $error("clock loss missed");

    property p_edge;
        @(posedge core_clk) disable iff (rst)
        bit_tick |-> (st_r.cfg.edge_sel ? (!st_r.tclk_s[1] && st_r.tclk_s[2])
                                        : (st_r.tclk_s[1] && !st_r.tclk_s[2]));
    endproperty
    a_edge: assert property (p_edge) else $error("wrong edge");

    property p_ami;
        @(posedge core_clk) disable iff (rst)
        (bit_tick && !st_r.cfg.rail && !st_r.cfg.enc)
        |=> (st_r.ent[0] == ltxe_pkg::sym_one) == $past(d_pos);
    endproperty
    a_ami: assert property (p_ami) else $error("bad data level");

    property p_dual;
        @(posedge core_clk) disable iff (rst)
        (bit_tick && st_r.cfg.rail) |=>
        line_tx_pair_neg == $past(d_pos && !d_neg) &&
        line_tx_pair_pos == $past(!d_pos && d_neg);
    endproperty
    a_dual: assert property (p_dual) else $error("dual rail map");

    property p_b8zs;
        @(posedge core_clk) disable iff (rst)
        (bit_tick && !st_r.cfg.rail && st_r.cfg.enc && st_r.cfg.line_std
         && !d_pos && st_r.ent[6:0] == '0)
        |=> st_r.ent[4] == ltxe_pkg::sym_viol;
    endproperty
    a_b8zs: assert property (p_b8zs) else $error("no B8ZS");

    property p_hdb3;
        @(posedge core_clk) disable iff (rst)
        (bit_tick && !st_r.cfg.rail && st_r.cfg.enc && !st_r.cfg.line_std
         && !d_pos && st_r.ent[2:0] == '0)
        |=> st_r.ent[0] == ltxe_pkg::sym_viol;
    endproperty
    a_hdb3: assert property (p_hdb3) else $error("no HDB3");

    property p_ram;
        @(posedge core_clk) disable iff (rst)
        s_trig |=> s_done_clear;
    endproperty
    a_ram: assert property (p_ram) else $error("trigger stuck");

    property p_rdback;
        @(posedge core_clk) disable iff (rst)
        (st_r.ram_go && st_r.cfg.rw)
        |=> st_r.cfg.sample == $past(wave_ram[ram_addr]);
    endproperty
    a_rdback: assert property (p_rdback) else $error("readback");

    property p_ovf;
        @(posedge core_clk) disable iff (rst)
        (arb_mode && wave_ovf) |=> st_r.cfg.status[`LTXE_ST_OVF]
            && (irq || !$past(st_r.cfg.mask[`LTXE_ST_OVF]));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow irq");

    property p_noscale;
        @(posedge core_clk) disable iff (rst)
        !arb_mode |=> line_tx_pair_amp == $past(pre_dac);
    endproperty
    a_noscale: assert property (p_noscale) else $error("preset scaled");

    property p_wait;
        @(posedge core_clk) disable iff (rst)
        (req && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus stall");

endmodule

// file: testbench/ltxe_far_model.sv
`timescale 1ns/1ps
// Framer stand-in; its clock stands still while run is low
module ltxe_far_model (
    // Control from the bench
    input  wire logic run,
    input  wire logic pos,
    input  wire logic neg,
    // Transmit pins
    output logic      tx_clock_in,
    output logic      tx_data_pos_in,
    output logic      tx_data_neg_in
);
    // 48 ns bit period, parked low when stopped
    initial
    begin
        tx_clock_in = 1'b0;
        tx_data_pos_in = 1'b0;
        tx_data_neg_in = 1'b0;
        forever #24 tx_clock_in = run ? ~tx_clock_in : 1'b0;
    end
    // Data moves on the falling edge; the bench holds it for many bits
    // so that either sampling edge finds it settled
    always @(negedge tx_clock_in)
    begin
        tx_data_pos_in <= pos;
        tx_data_neg_in <= neg;
    end
endmodule

// file: testbench/ltxe_tb.sv
`timescale 1ns/1ps
module ltxe_tb;
    logic        core_clk = 0, rst = 1, run = 1, pos = 0, neg = 0;
    logic [9:0]  avs_address = 0;
    logic        avs_read = 0, avs_write = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic        avs_waitrequest, tx_clock_in, tx_data_pos_in;
    logic        tx_data_neg_in, line_tx_pair_pos, line_tx_pair_neg, irq;
    logic [6:0]  line_tx_pair_amp;
    logic [7:0]  rd, x, da [4];
    logic        seen;
    logic [5:0]  aa [4];
    int          n_mismatch = 0, checks_done = 0;
    initial
        forever #2 core_clk = ~core_clk;
    ltxe_top ltxe_top_i (.core_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .tx_clock_in, .tx_data_pos_in, .tx_data_neg_in,
        .line_tx_pair_pos, .line_tx_pair_neg, .line_tx_pair_amp, .irq);
    ltxe_far_model ltxe_far_model_i (.run, .pos, .neg, .tx_clock_in,
        .tx_data_pos_in, .tx_data_neg_in);
    ////////////////////////////////////////////////////////////////////
    // Compare one byte result
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // One Avalon access; held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, wd};
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd = avs_readdata[7:0];
        avs_write <= 0;
        avs_read <= 0;
        @(posedge core_clk);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watchdog against a hung handshake
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    // Main sequence
    initial
    begin
        void'($urandom(92387));
        repeat (4) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        bus(0, 8'h04, 0);
        chk(rd, 8'h20);
        bus(0, 8'h33, 0);
        chk(rd, 8'h00);
        bus(1, 8'h17, 8'hff);
        bus(0, 8'h17, 0);
        chk(rd, 8'h00);
        // RAM writes, one per UI, random sample and data
        for (int i = 0; i < 4; i++)
        begin
            aa[i] = {i[1:0], 4'($urandom)};
            da[i] = {1'b0, 7'($urandom)};
            bus(1, 8'h06, da[i]);
            bus(1, 8'h05, {2'b10, aa[i]});
            bus(0, 8'h05, 0);
            chk(rd & 8'h80, 8'h00);
        end
        // Read back in reverse order over a cleared data field
        for (int i = 3; i >= 0; i--)
        begin
            bus(1, 8'h06, 8'h00);
            bus(1, 8'h05, {2'b11, aa[i]});
            bus(0, 8'h06, 0);
            chk(rd, da[i]);
        end
        // Dual rail: every pattern, both levels, random standard
        for (int j = 0; j < 8; j++)
        begin
            x = 8'($urandom);
            bus(1, 8'h40, {7'h0, x[0]});
            bus(1, 8'h02, {4'h0, x[1], j[2], 1'b1, x[2]});
            pos <= j[1];
            neg <= j[0];
            repeat (40) @(posedge core_clk);
            x[1] = j[1] ^ j[2];
            x[0] = j[0] ^ j[2];
            chk({line_tx_pair_pos, line_tx_pair_neg},
                {!x[1] & x[0], x[1] & !x[0]});
        end
        // Short clock gap stays silent, long gap flags loss
        bus(1, 8'h12, 8'h01);
        run <= 0;
        repeat (40) @(posedge core_clk);
        run <= 1;
        repeat (30) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00);
        run <= 0;
        repeat (100) @(posedge core_clk);
        chk({7'h0, irq}, 8'h01);
        run <= 1;
        bus(0, 8'h17, 0);
        chk(rd & 8'h01, 8'h01);
        repeat (30) @(posedge core_clk);
        bus(0, 8'h17, 0);
        chk(rd & 8'h01, 8'h00);
        chk({7'h0, irq}, 8'h00);
        // Single rail zeros: silent under AMI, substituted otherwise
        for (int k = 0; k < 4; k++)
        begin
            bus(1, 8'h40, {7'h0, k[1]});
            bus(1, 8'h02, {7'h0, k[0]});
            pos <= 0;
            repeat (160) @(posedge core_clk);
            seen = 0;
            repeat (300) @(posedge core_clk)
                seen |= line_tx_pair_pos | line_tx_pair_neg;
            chk({7'h0, seen}, {7'h0, k[0]});
        end
        // Preset amplitude: positive, and deaf to the scaling field
        bus(1, 8'h02, 8'h02);
        pos <= 0;
        neg <= 1;
        for (int k = 0; k < 2; k++)
        begin
            bus(1, 8'h40, {7'h0, k[0]});
            bus(1, 8'h03, k[0] ? 8'h07 : 8'h01);
            bus(1, 8'h04, 8'h20);
            repeat (40) @(posedge core_clk);
            x = {1'b0, line_tx_pair_amp};
            chk({7'h0, x[6] | ~|x[5:0]}, 8'h00);
            bus(1, 8'h04, 8'h3f);
            repeat (40) @(posedge core_clk);
            chk({1'b0, line_tx_pair_amp}, x);
        end
        // Full-scale samples everywhere: overlapping pulses overflow
        bus(1, 8'h06, 8'h3f);
        for (int i = 0; i < 64; i++)
            bus(1, 8'h05, {2'b10, 6'(i)});
        bus(1, 8'h12, 8'h02);
        bus(1, 8'h03, 8'h0c);
        repeat (60) @(posedge core_clk);
        chk({1'b0, line_tx_pair_amp}, 8'h3f);
        chk({7'h0, irq}, 8'h01);
        bus(0, 8'h17, 0);
        chk(rd & 8'h02, 8'h02);
        print_verdict;
    end
endmodule
